// ==== hw/flic_defs.svh ====
// register offsets, field positions, reset values and timing counts
// assumes byte addressing on a 32-bit AXI4-Lite register bus
`ifndef FLIC_DEFS_SVH
`define FLIC_DEFS_SVH
`define FLIC_OFS_TIMER_CTRL 8'h88
`define FLIC_OFS_FLAGS 8'h8C
`define FLIC_OFS_SRC_EN 8'hA8
`define FLIC_OFS_PRIO_LO 8'hB8
`define FLIC_OFS_PRIO_HI 8'hBC
`define FLIC_OFS_STATUS 8'hC0
`define FLIC_CLK_NS 25
`define FLIC_MC_NS 300
`define FLIC_MC_DIV ((`FLIC_MC_NS + `FLIC_CLK_NS - 1) / `FLIC_CLK_NS)
`define FLIC_NSRC 6
`define FLIC_NFLAG 8
`define FLIC_GLOBAL_BIT 7
`define FLIC_RST_BYTE 8'h00
`define FLIC_RESP_OKAY 2'b00
`define FLIC_RESP_SLVERR 2'b10
`endif

// ==== hw/flic_pkg.sv ====
// types shared by the interrupt controller modules
// assumes flic_defs.svh is on the include path
package flic_pkg;
   typedef logic [1:0] flic_level_t;
   typedef logic [2:0] flic_index_t;
   typedef enum logic [2:0] {
      SEL_NONE, SEL_TCTRL, SEL_FLAGS, SEL_EN, SEL_PLO, SEL_PHI, SEL_STAT
   } flic_sel_e;
   typedef enum {AW_IDLE, AW_RESP} flic_wstate_e;
endpackage

// ==== hw/flic_ext_flag.sv ====
// one external request flag: level or falling-edge capture of a pin
// assumes i_tick is a one-clock machine-cycle pulse
`timescale 1ns/100ps
`default_nettype none
module flic_ext_flag
   import flic_pkg::*;
(
   input wire logic i_clk,       // clock
   input wire logic i_arst_n,    // async reset
   input wire logic i_tick,      // sample phase pulse
   input wire logic i_pin_n,     // request pin, low active
   input wire logic i_edge_mode, // 1 edge, 0 level
   input wire logic i_sw_we,     // software write strobe
   input wire logic i_sw_val,    // software write value
   input wire logic i_ack_clr,   // vectored clear
   output logic o_flag           // request flag
);
   logic pin_q_ff;
   logic flag_ff;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pin_q_ff <= 1'b1;
      end else if (i_tick) begin
         pin_q_ff <= i_pin_n;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         flag_ff <= 1'b0;
      end else if (!i_edge_mode && i_tick) begin
         flag_ff <= ~i_pin_n;
      end else if (i_edge_mode && i_tick && pin_q_ff && !i_pin_n) begin
         flag_ff <= 1'b1; // set beats any clear
      end else if (i_sw_we) begin
         flag_ff <= i_sw_val;
      end else if (i_edge_mode && i_ack_clr) begin
         flag_ff <= 1'b0; // only edge mode clears on vector
      end
   end

   assign o_flag = flag_ff;
endmodule
`default_nettype wire

// ==== hw/flic_prio_sel.sv ====
// picks the winning request: highest level, then fixed polling order
// assumes index 0 is first in the polling order
`timescale 1ns/100ps
`default_nettype none
module flic_prio_sel
   import flic_pkg::*;
(
   input wire logic [5:0] i_req,     // enabled sampled requests
   input wire logic [5:0] i_plo,     // low priority bits
   input wire logic [5:0] i_phi,     // high priority bits
   output logic o_valid,             // some request pending
   output flic_index_t o_idx,        // winning source
   output flic_level_t o_lvl         // winning level
);
   always_comb begin
      o_valid = 1'b0;
      o_idx = 3'h0;
      o_lvl = 2'h0;
      // strict compare keeps the earliest source on a tie
      for (int i = 0; i < 6; i++) begin
         if (i_req[i] && (!o_valid || {i_phi[i], i_plo[i]} > o_lvl)) begin
            o_valid = 1'b1;
            o_idx = 3'(i);
            o_lvl = {i_phi[i], i_plo[i]};
         end
      end
   end
endmodule
`default_nettype wire

// ==== hw/flic_top.sv ====
// four-level interrupt controller with AXI4-Lite register access
// assumes the core reports instruction end and return-from-handler
//
// Operation
// - six sources: two external pins, timer 0, timer 1, serial, timer 2
// - each external input selects level or edge mode by its own bit
// - vectoring clears an external flag only in edge mode
// - in level mode the external flag follows the pin
// - timer 0/1 flags set on rollover, cleared when vectored
// - serial request is receive OR transmit done, never cleared by hardware
// - software writes set or clear flags just like hardware
// - per-source enable bits plus a global enable bit
// - two priority bits per source give four levels
// - preemption only by strictly higher level; level 3 never preempted
// - among different levels the higher level wins
// - equal-level ties use the fixed polling order
// - flags sampled each machine cycle, polled in the next
// - no vector while equal or higher level is in progress
// - vector only in the last cycle of the current instruction
// - after return or enable/priority write, one more instruction runs
// - blocked requests are not remembered; each poll uses fresh samples
// - low priority register holds bits 5..0, bits 7..6 unused
// - high priority register uses the same bit positions
// - select 0 means low level, 1 means high then low sample
// - return-from-handler ends the current in-progress level unless an accept falls in the same cycle
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "flic_defs.svh"
module flic_top
   import flic_pkg::*;
(
   input wire logic I_CLOCK,          // 40 MHz clock
   input wire logic I_ARST_N,         // async reset, low active
   input wire logic I_EXT0_REQ_N,     // external request 0 pin
   input wire logic I_EXT1_REQ_N,     // external request 1 pin
   input wire logic I_TIMER0_ROLL,    // timer 0 rollover pulse
   input wire logic I_TIMER1_ROLL,    // timer 1 rollover pulse
   input wire logic I_RX_DONE,        // receive done pulse
   input wire logic I_TX_DONE,        // transmit done pulse
   input wire logic I_T2_OVF,         // timer 2 overflow pulse
   input wire logic I_T2_EXT,         // timer 2 external pulse
   input wire logic I_INSN_LAST,      // current cycle ends instruction
   input wire logic I_RETURN,         // return-from-handler pulse
   output logic O_VEC_CALL,           // vector call pulse
   output logic [2:0] O_VEC_INDEX,    // vectored source
   output logic [3:0] O_IN_PROGRESS,  // busy levels
   output logic O_SAMPLE_PHASE,       // machine-cycle tick
   input wire logic [7:0] S_AXI_AWADDR,  // write address
   input wire logic S_AXI_AWVALID,       // write address valid
   output logic S_AXI_AWREADY,           // write address ready
   input wire logic [31:0] S_AXI_WDATA,  // write data
   input wire logic [3:0] S_AXI_WSTRB,   // byte strobes
   input wire logic S_AXI_WVALID,        // write data valid
   output logic S_AXI_WREADY,            // write data ready
   output logic [1:0] S_AXI_BRESP,       // write response
   output logic S_AXI_BVALID,            // write response valid
   input wire logic S_AXI_BREADY,        // write response ready
   input wire logic [7:0] S_AXI_ARADDR,  // read address
   input wire logic S_AXI_ARVALID,       // read address valid
   output logic S_AXI_ARREADY,           // read address ready
   output logic [31:0] S_AXI_RDATA,      // read data
   output logic [1:0] S_AXI_RRESP,       // read response
   output logic S_AXI_RVALID,            // read data valid
   input wire logic S_AXI_RREADY         // read data ready
);
   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function automatic flic_sel_e reg_sel(input logic [7:0] addr);
      case (addr)
         `FLIC_OFS_TIMER_CTRL: reg_sel = SEL_TCTRL;
         `FLIC_OFS_FLAGS: reg_sel = SEL_FLAGS;
         `FLIC_OFS_SRC_EN: reg_sel = SEL_EN;
         `FLIC_OFS_PRIO_LO: reg_sel = SEL_PLO;
         `FLIC_OFS_PRIO_HI: reg_sel = SEL_PHI;
         `FLIC_OFS_STATUS: reg_sel = SEL_STAT;
         default: reg_sel = SEL_NONE;
      endcase
   endfunction

   // highest busy level, valid bit on top
   function automatic logic [2:0] top_busy(input logic [3:0] busy);
      top_busy = 3'h0;
      for (int i = 0; i < 4; i++) begin
         if (busy[i]) begin
            top_busy = {1'b1, 2'(i)};
         end
      end
   endfunction

   // ------------------------------------------------------------
   // machine-cycle divider
   // ------------------------------------------------------------
   logic [4:0] div_cnt_ff;
   logic tick_ff;

   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         div_cnt_ff <= 5'h0;
         tick_ff <= 1'b0;
      end else if (div_cnt_ff == 5'(`FLIC_MC_DIV - 1)) begin
         div_cnt_ff <= 5'h0;
         tick_ff <= 1'b1;
      end else begin
         div_cnt_ff <= div_cnt_ff + 5'h1;
         tick_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   logic [7:0] awaddr_ff;
   logic [7:0] wdata_ff;
   logic wstrb0_ff;
   logic aw_have_ff, w_have_ff;
   flic_wstate_e wstate_ff;
   logic wr_do;
   flic_sel_e wr_sel;
   logic [7:0] tctrl_ff, en_ff, plo_ff, phi_ff;
   logic [7:0] flags;
   logic [3:0] busy_ff;
   flic_index_t last_idx_ff;

   assign wr_do = (wstate_ff == AW_IDLE) && aw_have_ff && w_have_ff;
   assign wr_sel = reg_sel(awaddr_ff);

   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff <= 8'h00;
         wstrb0_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `FLIC_RESP_OKAY;
         wstate_ff <= AW_IDLE;
      end else begin
         case (wstate_ff)
            AW_IDLE: begin
               if (S_AXI_AWVALID && awready_ff) begin
                  awaddr_ff <= S_AXI_AWADDR;
                  aw_have_ff <= 1'b1;
                  awready_ff <= 1'b0;
               end
               if (S_AXI_WVALID && wready_ff) begin
                  wdata_ff <= S_AXI_WDATA[7:0];
                  wstrb0_ff <= S_AXI_WSTRB[0];
                  w_have_ff <= 1'b1;
                  wready_ff <= 1'b0;
               end
               if (wr_do) begin
                  bvalid_ff <= 1'b1;
                  bresp_ff <= (wr_sel == SEL_NONE) ? `FLIC_RESP_SLVERR : `FLIC_RESP_OKAY;
                  wstate_ff <= AW_RESP;
               end
            end
            AW_RESP: begin
               if (S_AXI_BREADY) begin
                  bvalid_ff <= 1'b0;
                  aw_have_ff <= 1'b0;
                  w_have_ff <= 1'b0;
                  awready_ff <= 1'b1;
                  wready_ff <= 1'b1;
                  wstate_ff <= AW_IDLE;
               end
            end
            default: wstate_ff <= AW_IDLE;
         endcase
      end
   end

   logic wr_byte;
   assign wr_byte = wr_do && wstrb0_ff;

   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= `FLIC_RESP_OKAY;
      end else if (rvalid_ff) begin
         if (S_AXI_RREADY) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
         end
      end else if (S_AXI_ARVALID && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rresp_ff <= `FLIC_RESP_OKAY;
         case (reg_sel(S_AXI_ARADDR))
            SEL_TCTRL: rdata_ff <= {24'h00_0000, tctrl_ff};
            SEL_FLAGS: rdata_ff <= {24'h00_0000, flags};
            SEL_EN: rdata_ff <= {24'h00_0000, en_ff};
            SEL_PLO: rdata_ff <= {24'h00_0000, plo_ff};
            SEL_PHI: rdata_ff <= {24'h00_0000, phi_ff};
            SEL_STAT: rdata_ff <= {25'h000_0000, last_idx_ff, busy_ff};
            default: begin
               rdata_ff <= 32'h0000_0000;
               rresp_ff <= `FLIC_RESP_SLVERR;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         tctrl_ff <= `FLIC_RST_BYTE;
         en_ff <= `FLIC_RST_BYTE;
         plo_ff <= `FLIC_RST_BYTE;
         phi_ff <= `FLIC_RST_BYTE;
      end else if (wr_byte) begin
         case (wr_sel)
            SEL_TCTRL: tctrl_ff <= {6'h00, wdata_ff[1:0]};
            SEL_EN: en_ff <= {wdata_ff[7], 1'b0, wdata_ff[5:0]};
            // bits 7..6 store nothing, writing ones there has no effect
            SEL_PLO: plo_ff <= {2'h0, wdata_ff[5:0]};
            SEL_PHI: phi_ff <= {2'h0, wdata_ff[5:0]};
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // request flags
   // ------------------------------------------------------------
   // flag bits: 0 ext0, 1 timer0, 2 ext1, 3 timer1, 4 rx, 5 tx,
   // 6 timer2 overflow, 7 timer2 external
   logic flag_we;
   logic accept;
   flic_index_t win_idx;
   logic [7:0] hw_set;
   logic [7:0] ack_clr;

   assign flag_we = wr_byte && (wr_sel == SEL_FLAGS);
   assign hw_set = {I_T2_EXT, I_T2_OVF, I_TX_DONE, I_RX_DONE,
                    I_TIMER1_ROLL, 1'b0, I_TIMER0_ROLL, 1'b0};
   // serial and timer 2 flags stay set for software
   assign ack_clr = {4'h0, accept && win_idx == 3'h3, accept && win_idx == 3'h2,
                     accept && win_idx == 3'h1, accept && win_idx == 3'h0};

   flic_ext_flag u_ext0 (
      .i_clk(I_CLOCK),
      .i_arst_n(I_ARST_N),
      .i_tick(tick_ff),
      .i_pin_n(I_EXT0_REQ_N),
      .i_edge_mode(tctrl_ff[0]),
      .i_sw_we(flag_we),
      .i_sw_val(wdata_ff[0]),
      .i_ack_clr(ack_clr[0]),
      .o_flag(flags[0])
   );

   flic_ext_flag u_ext1 (
      .i_clk(I_CLOCK),
      .i_arst_n(I_ARST_N),
      .i_tick(tick_ff),
      .i_pin_n(I_EXT1_REQ_N),
      .i_edge_mode(tctrl_ff[1]),
      .i_sw_we(flag_we),
      .i_sw_val(wdata_ff[2]),
      .i_ack_clr(ack_clr[2]),
      .o_flag(flags[2])
   );

   for (genvar g = 1; g < `FLIC_NFLAG; g++) begin : g_flag
      if (g != 2) begin : g_int
         logic f_ff;
         always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
            if (!I_ARST_N) begin
               f_ff <= 1'b0;
            end else if (hw_set[g]) begin
               f_ff <= 1'b1; // set wins over any clear
            end else if (flag_we) begin
               f_ff <= wdata_ff[g];
            end else if (ack_clr[g]) begin
               f_ff <= 1'b0;
            end
         end
         assign flags[g] = f_ff;
      end
   end

   // ------------------------------------------------------------
   // sampling, polling and vectoring
   // ------------------------------------------------------------
   logic [5:0] smp_ff;
   logic [5:0] req;
   logic win_valid;
   flic_level_t win_lvl;
   logic [2:0] busy_top;
   logic block_ff;
   logic vec_ff;

   // six sources in polling order
   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         smp_ff <= 6'h00;
      end else if (tick_ff) begin
         // overwritten every cycle, nothing from a blocked poll lingers
         smp_ff <= {flags[6] | flags[7], flags[4] | flags[5], flags[3:0]};
      end
   end

   assign req = smp_ff & en_ff[5:0] & {6{en_ff[`FLIC_GLOBAL_BIT]}};
   assign busy_top = top_busy(busy_ff);

   flic_prio_sel u_sel (
      .i_req(req),
      .i_plo(plo_ff[5:0]),
      .i_phi(phi_ff[5:0]),
      .o_valid(win_valid),
      .o_idx(win_idx),
      .o_lvl(win_lvl)
   );

   // level 3 can never exceed a busy level 3
   assign accept = tick_ff && win_valid && I_INSN_LAST && !block_ff
                   && (!busy_top[2] || win_lvl > busy_top[1:0]);

   // holds off vectoring until one more instruction has ended
   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         block_ff <= 1'b0;
      end else if (I_RETURN || (wr_do && (wr_sel == SEL_EN || wr_sel == SEL_PLO
                                          || wr_sel == SEL_PHI))) begin
         block_ff <= 1'b1;
      end else if (tick_ff && I_INSN_LAST) begin
         block_ff <= 1'b0;
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         busy_ff <= 4'h0;
      end else if (accept) begin
         busy_ff[win_lvl] <= 1'b1;
      end else if (I_RETURN && busy_top[2]) begin
         busy_ff[busy_top[1:0]] <= 1'b0;
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         vec_ff <= 1'b0;
         last_idx_ff <= 3'h0;
      end else begin
         vec_ff <= accept;
         if (accept) begin
            last_idx_ff <= win_idx;
         end
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign O_VEC_CALL = vec_ff;
   assign O_VEC_INDEX = last_idx_ff;
   assign O_IN_PROGRESS = busy_ff;
   assign O_SAMPLE_PHASE = tick_ff;
   assign S_AXI_AWREADY = awready_ff;
   assign S_AXI_WREADY = wready_ff;
   assign S_AXI_BVALID = bvalid_ff;
   assign S_AXI_BRESP = bresp_ff;
   assign S_AXI_ARREADY = arready_ff;
   assign S_AXI_RVALID = rvalid_ff;
   assign S_AXI_RDATA = rdata_ff;
   assign S_AXI_RRESP = rresp_ff;
endmodule
`default_nettype wire

// ==== testbench/flic_core_model.sv ====
// core-side model: instruction-end level and return pulses
// assumes i_tick is the controller's machine-cycle pulse
`timescale 1ns/100ps
`default_nettype none
module flic_core_model
   import flic_pkg::*;
(
   input wire logic i_clk, // clock
   input wire logic i_arst_n, // async reset
   input wire logic i_tick, // machine-cycle tick
   input wire logic i_slow, // two-cycle instructions
   input wire logic i_ret_req, // bench asks for a return
   output logic o_insn_last, // instruction ends this cycle
   output logic o_return // return-from-handler pulse
);
   // -----------------
   // sequencer
   // -----------------
   // slow mode ends an instruction only on every other cycle
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_insn_last <= 1'h1;
      end else if (i_tick) begin
         o_insn_last <= i_slow ? !o_insn_last : 1'h1;
      end
   end
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_return <= 1'h0;
      end else begin
         o_return <= i_ret_req;
      end
   end
endmodule
`default_nettype wire

// ==== testbench/flic_top_properties.sv ====
// assertions on the controller's core-side ports
// assumes one clock domain; bound into flic_top below
`timescale 1ns/100ps
`default_nettype none
module flic_top_properties
   import flic_pkg::*;
(
   input wire logic I_CLOCK, // clock
   input wire logic I_ARST_N, // async reset
   input wire logic I_INSN_LAST, // instruction end
   input wire logic I_RETURN, // return pulse
   input wire logic O_VEC_CALL, // vector call
   input wire logic [2:0] O_VEC_INDEX, // vector index
   input wire logic [3:0] O_IN_PROGRESS, // busy levels
   input wire logic O_SAMPLE_PHASE // tick
);
   // -----------------
   // properties
   // -----------------
   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (!I_ARST_N);
   sequence s_tick_gap;
      !O_SAMPLE_PHASE [*8] ##1 !O_SAMPLE_PHASE [*3];
   endsequence
   // a return racing an accept is dropped, so skip that case
   sequence s_ret_kept;
      I_RETURN && O_IN_PROGRESS != 4'h0 ##1 !O_VEC_CALL;
   endsequence
   property p_tick_period;
      O_SAMPLE_PHASE |=> s_tick_gap ##1 O_SAMPLE_PHASE;
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("tick spacing");
   property p_call_tick;
      O_VEC_CALL |-> $past(O_SAMPLE_PHASE);
   endproperty
   a_call_tick: assert property (p_call_tick) else $error("call off tick");
   property p_call_last;
      O_VEC_CALL |-> $past(I_INSN_LAST);
   endproperty
   a_call_last: assert property (p_call_last) else $error("call mid insn");
   property p_call_pulse;
      O_VEC_CALL |=> !O_VEC_CALL [*8];
   endproperty
   a_call_pulse: assert property (p_call_pulse) else $error("call too long");
   property p_idx;
      O_VEC_CALL |-> O_VEC_INDEX <= 3'h5;
   endproperty
   a_idx: assert property (p_idx) else $error("bad index");
   property p_busy_up;
      O_IN_PROGRESS > $past(O_IN_PROGRESS) |-> O_VEC_CALL;
   endproperty
   a_busy_up: assert property (p_busy_up) else $error("busy without call");
   property p_preempt;
      O_VEC_CALL |-> {1'h0, O_IN_PROGRESS} > {$past(O_IN_PROGRESS), 1'h0};
   endproperty
   a_preempt: assert property (p_preempt) else $error("level not higher");
   property p_ret;
      s_ret_kept |-> O_IN_PROGRESS < $past(O_IN_PROGRESS);
   endproperty
   a_ret: assert property (p_ret) else $error("return kept busy");
   property p_busy_down;
      O_IN_PROGRESS < $past(O_IN_PROGRESS) |-> $past(I_RETURN);
   endproperty
   a_busy_down: assert property (p_busy_down) else $error("busy dropped");
   property p_ret_hold;
      I_RETURN |-> ##2 !O_VEC_CALL [*8];
   endproperty
   a_ret_hold: assert property (p_ret_hold) else $error("call right after return");
endmodule
bind flic_top flic_top_properties i_props (
   .I_CLOCK(I_CLOCK),
   .I_ARST_N(I_ARST_N),
   .I_INSN_LAST(I_INSN_LAST),
   .I_RETURN(I_RETURN),
   .O_VEC_CALL(O_VEC_CALL),
   .O_VEC_INDEX(O_VEC_INDEX),
   .O_IN_PROGRESS(O_IN_PROGRESS),
   .O_SAMPLE_PHASE(O_SAMPLE_PHASE)
);
`default_nettype wire

// ==== testbench/flic_tb_top.sv ====
// self-checking bench for the interrupt controller
// assumes core model and checker compiled alongside
`timescale 1ns/100ps
`default_nettype none
`include "flic_defs.svh"
module flic_tb_top
   import flic_pkg::*;
;
   localparam logic [1:0] rok = `FLIC_RESP_OKAY;
   localparam logic [1:0] rse = `FLIC_RESP_SLVERR;
   localparam logic [7:0] a_tc = `FLIC_OFS_TIMER_CTRL;
   localparam logic [7:0] a_fl = `FLIC_OFS_FLAGS;
   localparam logic [7:0] a_en = `FLIC_OFS_SRC_EN;
   localparam logic [7:0] a_pl = `FLIC_OFS_PRIO_LO;
   localparam logic [7:0] a_ph = `FLIC_OFS_PRIO_HI;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic p0_n = 1'h1;
   logic p1_n = 1'h1;
   logic [5:0] pls = 6'h00;
   logic slow = 1'h0;
   logic ret_req = 1'h0;
   logic insn_last, ret, call, tick;
   flic_index_t idx;
   logic [3:0] busy;
   logic [7:0] awa = 8'h00;
   logic [7:0] ara = 8'h00;
   logic [31:0] wd = 32'h0000_0000;
   logic [3:0] ws = 4'h0;
   logic awv = 1'h0;
   logic wv = 1'h0;
   logic br = 1'h0;
   logic arv = 1'h0;
   logic rr = 1'h0;
   logic awr, wr_rdy, bv, arr, rv;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int error_cnt = 0;
   int checked = 0;
   flic_top i_dut (
      .I_CLOCK(clk), .I_ARST_N(rst_n),
      .I_EXT0_REQ_N(p0_n), .I_EXT1_REQ_N(p1_n),
      .I_TIMER0_ROLL(pls[0]), .I_TIMER1_ROLL(pls[1]),
      .I_RX_DONE(pls[2]), .I_TX_DONE(pls[3]),
      .I_T2_OVF(pls[4]), .I_T2_EXT(pls[5]),
      .I_INSN_LAST(insn_last), .I_RETURN(ret),
      .O_VEC_CALL(call), .O_VEC_INDEX(idx),
      .O_IN_PROGRESS(busy), .O_SAMPLE_PHASE(tick),
      .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
      .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rv), .S_AXI_RREADY(rr)
   );
   flic_core_model i_core (
      .i_clk(clk), .i_arst_n(rst_n), .i_tick(tick), .i_slow(slow),
      .i_ret_req(ret_req), .o_insn_last(insn_last), .o_return(ret)
   );
   // -----------------
   // helpers
   // -----------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // this slave raises both write readies together, so wait for both
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
      @(posedge clk);
      awa <= a;
      wd <= {24'h00_0000, d};
      ws <= 4'hF;
      awv <= 1'h1;
      wv <= 1'h1;
      br <= 1'h1;
      do @(negedge clk); while (!(awr && wr_rdy));
      @(posedge clk);
      awv <= 1'h0;
      wv <= 1'h0;
      do @(negedge clk); while (bv !== 1'h1);
      chk({6'h00, bresp}, {6'h00, e});
      @(posedge clk);
      br <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
      @(posedge clk);
      ara <= a;
      arv <= 1'h1;
      rr <= 1'h1;
      do @(negedge clk); while (arr !== 1'h1);
      @(posedge clk);
      arv <= 1'h0;
      do @(negedge clk); while (rv !== 1'h1);
      chk(rdata[7:0], d);
      chk({6'h00, rresp}, {6'h00, e});
      @(posedge clk);
      rr <= 1'h0;
   endtask
   task automatic wait_call(input flic_index_t i, input logic [3:0] b);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (call !== 1'h1 && n < 300);
      chk({7'h00, call}, 8'h01);
      chk({5'h00, idx}, {5'h00, i});
      chk({4'h0, busy}, {4'h0, b});
      @(negedge clk);
   endtask
   task automatic no_call(input int n);
      int c;
      c = 0;
      repeat (n) begin
         @(negedge clk);
         if (call !== 1'h0) c++;
      end
      chk(c[7:0], 8'h00);
   endtask
   task automatic pulse(input logic [5:0] m);
      @(posedge clk);
      pls <= m;
      @(posedge clk);
      pls <= 6'h00;
   endtask
   task automatic do_ret();
      @(posedge clk);
      ret_req <= 1'h1;
      @(posedge clk);
      ret_req <= 1'h0;
   endtask
   // -----------------
   // scenarios
   // -----------------
   task automatic t_regs();
      rd(a_en, 8'h00, rok);
      rd(a_pl, 8'h00, rok);
      wr(a_pl, 8'h3F, rok);
      rd(a_pl, 8'h3F, rok);
      wr(a_ph, 8'h15, rok);
      rd(a_ph, 8'h15, rok);
      wr(8'h04, 8'h3F, rse);
      rd(8'h04, 8'h00, rse);
      wr(a_pl, 8'h00, rok);
      wr(a_ph, 8'h00, rok);
      $display("test regs done");
   endtask
   task automatic t_edge();
      wr(a_tc, 8'h01, rok);
      wr(a_en, 8'h01, rok);
      p0_n <= 1'h0;
      no_call(80);
      wr(a_en, 8'h81, rok);
      wait_call(3'h0, 4'h1);
      rd(a_fl, 8'h00, rok);
      do_ret();
      p0_n <= 1'h1;
      $display("test edge done");
   endtask
   task automatic t_level();
      wr(a_tc, 8'h00, rok);
      wr(a_en, 8'h84, rok);
      slow <= 1'h1;
      p1_n <= 1'h0;
      wait_call(3'h2, 4'h1);
      rd(a_fl, 8'h04, rok);
      p1_n <= 1'h1;
      repeat (40) @(posedge clk);
      rd(a_fl, 8'h00, rok);
      do_ret();
      slow <= 1'h0;
      $display("test level done");
   endtask
   task automatic t_tie();
      wr(a_en, 8'hB8, rok);
      pulse(6'h26);
      wait_call(3'h3, 4'h1);
      do_ret();
      wait_call(3'h4, 4'h1);
      rd(a_fl, 8'h90, rok);
      wr(a_fl, 8'h80, rok);
      do_ret();
      wait_call(3'h5, 4'h1);
      rd(`FLIC_OFS_STATUS, 8'h51, rok);
      wr(a_fl, 8'h00, rok);
      do_ret();
      $display("test tie done");
   endtask
   task automatic t_prio();
      wr(a_en, 8'h8A, rok);
      wr(a_pl, 8'h02, rok);
      wr(a_ph, 8'h08, rok);
      pulse(6'h03);
      wait_call(3'h3, 4'h4);
      no_call(60);
      do_ret();
      wait_call(3'h1, 4'h2);
      do_ret();
      wr(a_pl, 8'h0A, rok);
      wr(a_ph, 8'h0A, rok);
      pulse(6'h02);
      wait_call(3'h3, 4'h8);
      wr(a_fl, 8'h02, rok);
      no_call(60);
      wr(a_fl, 8'h00, rok);
      do_ret();
      no_call(60);
      $display("test prio done");
   endtask
   task automatic finish_test();
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'h1;
      t_regs();
      t_edge();
      t_level();
      t_tie();
      t_prio();
      finish_test();
   end
   // whole run needs under a thousand clocks
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      $display("unexpected at %0t: watchdog expired", $time);
      finish_test();
   end
endmodule
`default_nettype wire
